/* File: logic/itr_pkg.sv */
// constants and types of the serial target read engine
package itr_pkg;
   // -------------------------------------------------------------
   // bus addressing
   // -------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h41;
   localparam logic RW_READ = 1'h1;
   localparam int BYTE_W = 8;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // byte sent when the prefetch buffer ran dry: line stays released
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   // -------------------------------------------------------------
   // register pointer and prefetch buffer
   // -------------------------------------------------------------
   localparam int PTR_W = 8;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam int FIFO_DEPTH = 8;

   // -------------------------------------------------------------
   // protocol states
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b010,
      ST_TX = 3'b011,
      ST_RACK = 3'b100,
      ST_NEXT = 3'b101,
      ST_SKIP = 3'b110
   } itr_state_t;
endpackage

/* File: logic/itr_stream_if.sv */
// valid/ready byte stream between the engine and its prefetch buffer
`timescale 1ns/10ps
interface itr_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport tx (output valid, output data, input ready);
   modport rx (input valid, input data, output ready);
endinterface

/* File: logic/itr_fifo.sv */
// synchronous fifo with flush, stream interfaces on both sides
`timescale 1ns/10ps
module itr_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic flush_i,
   itr_stream_if.rx in_if,
   itr_stream_if.tx out_if
);
   import itr_pkg::*;

   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);
   wire push = in_if.valid && !full;
   wire pop = out_if.ready && !empty;

   assign in_if.ready = !full;
   assign out_if.valid = !empty;
   assign out_if.data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_q[wr_q[AW-1:0]] <= in_if.data;
      end
   end

   // flush beats push and pop so a new transfer starts clean
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else if (flush_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         wr_q <= wr_q + (AW+1)'(push);
         rd_q <= rd_q + (AW+1)'(pop);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // a push while full would overwrite the oldest unread word
   a_fifo_no_overrun: assert property (full && !flush_i |=> wr_q == $past(wr_q))
      else $error("fifo accepts while full");
endmodule

/* File: logic/itr_top.sv */
// serial bus target, read direction: address match, ack, byte transmit
`timescale 1ns/10ps
module itr_top #(
   parameter int PW = itr_pkg::PTR_W,
   parameter int DEPTH = itr_pkg::FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic ptr_load_i,
   input wire logic [PW-1:0] ptr_val_i,
   output logic [PW-1:0] ptr_o,
   output logic [PW-1:0] reg_addr_o,
   input wire logic [itr_pkg::BYTE_W-1:0] reg_data_i
);
   import itr_pkg::*;

   // -------------------------------------------------------------
   // pin synchronisers and bus events
   // -------------------------------------------------------------
   logic scl_m_q, scl_s_q, scl_p_q;
   logic sda_m_q, sda_s_q, sda_p_q;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      end
      else
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      end
   end

   wire scl_rise = scl_s_q && !scl_p_q;
   wire scl_fall = !scl_s_q && scl_p_q;
   wire scl_high = scl_s_q && scl_p_q;
   wire start_det = scl_high && !sda_s_q && sda_p_q;
   wire stop_det = scl_high && sda_s_q && !sda_p_q;
   wire bus_evt = start_det || stop_det;

   // -------------------------------------------------------------
   // prefetch path
   // -------------------------------------------------------------
   itr_stream_if #(.W(BYTE_W)) fill_if ();
   itr_stream_if #(.W(BYTE_W)) drain_if ();

   itr_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic [BYTE_W-1:0] sh_q, sh_d;
   logic oe_q, oe_d;
   logic [PW-1:0] ptr_q;
   logic [PW-1:0] fetch_q;
   logic fetch_run_q;

   wire addr_rd_hit = ({sh_q[BYTE_W-2:0], sda_s_q} == {DEV_ADDR, RW_READ});
   // eighth bit after start completes address byte
   wire addr_done = !bus_evt && scl_rise && (state_q == ST_ADDR) && (cnt_q == BIT_LAST);
   wire match_rd = addr_done && addr_rd_hit;
   wire load_byte = !bus_evt && scl_fall
      && (((state_q == ST_AACK) && oe_q) || (state_q == ST_NEXT));
   wire ptr_inc = !bus_evt && scl_rise && (state_q == ST_RACK);
   wire [BYTE_W-1:0] tx_byte = drain_if.valid ? drain_if.data : IDLE_BYTE;

   assign fill_if.valid = fetch_run_q;
   assign fill_if.data = reg_data_i;
   assign drain_if.ready = load_byte;

   // the buffer stalls the fetch once full: the source sees ready low
   itr_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .flush_i(bus_evt),
      .in_if(fill_if),
      .out_if(drain_if)
   );

   // -------------------------------------------------------------
   // protocol state machine
   // -------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      oe_d = oe_q;
      // start or stop resets protocol state
      if (start_det)
      begin
         state_d = ST_ADDR;
         cnt_d = '0;
         oe_d = 1'b0;
      end
      else if (stop_det)
      begin
         state_d = ST_IDLE;
         oe_d = 1'b0;
      end
      else
      begin
         case (state_q)
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  sh_d = {sh_q[BYTE_W-2:0], sda_s_q};
                  cnt_d = cnt_q + 3'h1;
                  // mismatch or write: stay off the bus
                  if (cnt_q == BIT_LAST)
                  begin
                     state_d = addr_rd_hit ? ST_AACK : ST_SKIP;
                  end
               end
            end
            ST_AACK, ST_NEXT:
            begin
               if (scl_fall)
               begin
                  // pull data low for ninth clock
                  if ((state_q == ST_AACK) && !oe_q)
                  begin
                     oe_d = 1'b1;
                  end
                  else
                  begin
                     state_d = ST_TX;
                     sh_d = tx_byte;
                     oe_d = !tx_byte[BYTE_W-1];
                     cnt_d = '0;
                  end
               end
            end
            ST_TX:
            begin
               // msb first, updated after clock falls
               if (scl_fall)
               begin
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == BIT_LAST)
                  begin
                     oe_d = 1'b0;
                     state_d = ST_RACK;
                  end
                  else
                  begin
                     sh_d = {sh_q[BYTE_W-2:0], 1'b0};
                     oe_d = !sh_q[BYTE_W-2];
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
               begin
                  state_d = sda_s_q ? ST_SKIP : ST_NEXT;
               end
            end
            ST_IDLE, ST_SKIP:
            begin
               state_d = state_q;
            end
            default:
            begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         oe_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         oe_q <= oe_d;
      end
   end

   // -------------------------------------------------------------
   // register pointer and fetch address
   // -------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ptr_q <= PW'(PTR_RST);
         fetch_q <= PW'(PTR_RST);
         fetch_run_q <= 1'b0;
      end
      else
      begin
         // pointer only moves by load or byte sent
         if (ptr_load_i)
         begin
            ptr_q <= ptr_val_i;
         end
         else if (ptr_inc)
         begin
            ptr_q <= ptr_q + PW'(1);
         end
         if (match_rd)
         begin
            fetch_q <= ptr_q;
            fetch_run_q <= 1'b1;
         end
         else if (bus_evt || (state_q == ST_SKIP))
         begin
            fetch_run_q <= 1'b0;
         end
         else if (fill_if.valid && fill_if.ready)
         begin
            fetch_q <= fetch_q + PW'(1);
         end
      end
   end

   // open drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_o = oe_q;
   assign ptr_o = ptr_q;
   assign reg_addr_o = fetch_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_read_addr;
      match_rd;
   endsequence
   sequence s_ack_driven;
      (state_q == ST_AACK) && sda_oe_o;
   endsequence
   sequence s_ack_due;
      (state_q == ST_AACK) && !sda_oe_o && scl_fall && !bus_evt;
   endsequence

   a_start_resets: assert property (start_det |=> state_q == ST_ADDR && cnt_q == 3'h0)
      else $error("start did not restart address phase");
   a_stop_idles: assert property (stop_det |=> state_q == ST_IDLE && !sda_oe_o)
      else $error("stop did not idle and release");
   a_addr_match: assert property (s_read_addr |=> state_q == ST_AACK)
      else $error("matching read address not taken");
   a_no_ack_skip: assert property (state_q == ST_SKIP |-> !sda_oe_o)
      else $error("line driven while ignoring bus");
   a_ack_ninth: assert property (s_ack_due |=> s_ack_driven)
      else $error("no ack after address match");
   a_fetch_ptr: assert property (s_read_addr |=> reg_addr_o == $past(ptr_q) && fill_if.valid)
      else $error("prefetch not started from pointer");
   a_ptr_step: assert property (ptr_inc && !ptr_load_i |=> ptr_o == $past(ptr_o) + PW'(1))
      else $error("pointer did not step by one");
   a_nack_release: assert property (ptr_inc && sda_s_q |=> state_q == ST_SKIP && !sda_oe_o)
      else $error("line not released after not-ack");
   a_msb_first: assert property (load_byte |=> sda_oe_o == !$past(tx_byte[BYTE_W-1]))
      else $error("first driven bit is not msb");
   a_change_low: assert property ($changed(sda_oe_o) && !$past(bus_evt) |-> !scl_s_q)
      else $error("data changed while clock high");
endmodule

/* File: verif/itr_ctl_model.sv */
// bus controller model issuing read transfers to the target
`timescale 1ns/10ps
module itr_ctl_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o,
   output logic [7:0] rx_byte_o,
   output logic rx_stb_o
);
   // clock stands high and data released between frames
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_stb_o = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic put_bit(input logic b, output logic r);
      sda_oe_o = ~b;
      hold(4);
      scl_o = 1'b1;
      hold(4);
      r = sda_i;
      hold(4);
      scl_o = 1'b0;
      hold(4);
   endtask

   // also serves as repeated start
   task automatic start;
      sda_oe_o = 1'b0;
      hold(4);
      scl_o = 1'b1;
      hold(8);
      sda_oe_o = 1'b1;
      hold(8);
      scl_o = 1'b0;
      hold(4);
   endtask

   task automatic stop;
      sda_oe_o = 1'b1;
      hold(4);
      scl_o = 1'b1;
      hold(8);
      sda_oe_o = 1'b0;
      hold(8);
   endtask

   // address, then ack all but last
   task automatic xfer(input logic [7:0] ab, input int n, input bit fin, output logic nak);
      logic r;
      logic [7:0] b;
      start();
      for (int i = 7; i >= 0; i--)
         put_bit(ab[i], r);
      put_bit(1'b1, nak);
      for (int k = 0; k < n; k++)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            put_bit(1'b1, r);
            b[i] = r;
         end
         rx_byte_o = b;
         rx_stb_o = 1'b1;
         put_bit(k == n - 1, r);
         rx_stb_o = 1'b0;
      end
      if (fin)
         stop();
   endtask
endmodule

/* File: verif/itr_top_test.sv */
// self-checking bench for the serial target read engine
`timescale 1ns/10ps
module itr_top_test;
   import itr_pkg::*;
   logic clk, rst_n, scl, sda_w, dut_oe, dut_o, m_oe, ptr_load, rx_stb;
   logic [7:0] ptr_val, ptr, reg_addr, reg_data, rx_byte, exp_ptr, ab;
   logic [7:0] mem [256];
   logic [7:0] exp_q [$];
   int err_total = 0;
   int n_tests = 0;
   int seed = 3;
   int cycles = 0;

   // open-drain wire with pull-up
   assign sda_w = ~(m_oe | (dut_oe & ~dut_o));
   assign reg_data = mem[reg_addr];

   itr_top #(.PW(PTR_W), .DEPTH(FIFO_DEPTH)) uut (
      .clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(dut_o),
      .sda_oe_o(dut_oe), .ptr_load_i(ptr_load), .ptr_val_i(ptr_val), .ptr_o(ptr),
      .reg_addr_o(reg_addr), .reg_data_i(reg_data));

   itr_ctl_model ctl (
      .clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_oe_o(m_oe), .rx_byte_o(rx_byte),
      .rx_stb_o(rx_stb));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t byte got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD %0t bit got %b want %b", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // byte stands through the whole ack bit, so take it as the strobe drops
   always @(negedge rx_stb)
   begin
      if (exp_q.size() == 0)
         chk_bit(1'b0, 1'b1);
      else
         chk_byte(rx_byte, exp_q.pop_front());
   end

   // data line may only move while the bus clock is low
   always @(dut_oe)
      if (rst_n === 1'b1)
         chk_bit(scl, 1'b0);

   // limit sized for about a dozen transfers of up to four bytes
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         $display("BAD %0t timeout", $time);
         end_sim();
      end
   end

   // ---------------------------------------------------------------
   // stimulus
   // ---------------------------------------------------------------
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic load(input logic [7:0] v);
      ptr_val = v;
      ptr_load = 1'b1;
      hold(1);
      ptr_load = 1'b0;
      exp_ptr = v;
   endtask

   // ignored transfers see a released line, so all ones
   task automatic run(input logic [7:0] a, input int n, input bit fin);
      logic nak;
      logic hit;
      hit = (a == {DEV_ADDR, RW_READ});
      for (int k = 0; k < n; k++)
         exp_q.push_back(hit ? mem[8'(exp_ptr + k)] : 8'hff);
      ctl.xfer(a, n, fin, nak);
      chk_bit(nak, ~hit);
      if (hit)
         exp_ptr = exp_ptr + 8'(n);
      hold(2);
      chk_byte(ptr, exp_ptr);
      chk_bit(sda_w, 1'b1);
   endtask

   initial
   begin
      rst_n = 1'b0;
      ptr_load = 1'b0;
      ptr_val = 8'h00;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'($random(seed));
      exp_ptr = PTR_RST;
      hold(5);
      rst_n = 1'b1;
      chk_byte(ptr, 8'h00);
      chk_bit(dut_oe, 1'b0);
      hold(4);
      run({DEV_ADDR, RW_READ}, 2, 1'b1);
      load(8'hfe);
      run({DEV_ADDR, RW_READ}, 3, 1'b1);
      run({DEV_ADDR, 1'b0}, 1, 1'b1);
      run({7'h40, RW_READ}, 2, 1'b1);
      run({DEV_ADDR, RW_READ}, 1, 1'b0);
      run({DEV_ADDR, RW_READ}, 4, 1'b1);
      repeat (6)
      begin
         if ($random(seed) & 1)
            load(8'($random(seed)));
         ab = ({$random(seed)} % 3 == 0) ? 8'($random(seed)) : {DEV_ADDR, RW_READ};
         run(ab, 1 + {$random(seed)} % 4, 1'($random(seed)));
      end
      run({DEV_ADDR, RW_READ}, 1, 1'b1);
      hold(10);
      chk_bit(exp_q.size() == 0, 1'b1);
      end_sim();
   end
endmodule
